// [hdl/qfg_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "qfg_regs.svh"

module qfg_top #(
  parameter int unsigned P_TIMER_CYCLES = `QFG_TIMER_CYCLES
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  // avalon-mm slave
  input wire logic [7:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // link status
  input wire logic [3:0] I_LINK_INT,
  input wire logic [3:0] I_LOSS_OF_SIGNAL,
  input wire logic [3:0] I_RECOVERED_CLK,
  input wire logic I_MASTER_CLK,
  input wire qfg_pkg::qfg_link_counts_t [3:0] I_LINK_COUNTS,
  // line monitor
  input wire logic [3:0] I_LINK_RX_DATA,
  input wire logic [3:0] I_LINK_TX_DATA,
  output logic O_MONITOR_DATA,
  output logic O_MONITOR_ACTIVE,
  // general-purpose pins
  input wire logic [1:0] I_GPIO,
  output logic [1:0] O_GPIO,
  output logic [1:0] O_GPIO_OE,
  // reference clocks and interrupt
  output logic O_FIRST_REFCLK_OUTPUT,
  output logic O_SECOND_REFCLK_OUTPUT,
  output logic O_INT_N
);
  import qfg_pkg::*;

  // ==========================================
  // state and bus decode
  qfg_state_t s_reg;
  qfg_state_t s_next;
  logic [5:0] idx;
  logic req;
  logic wr_en;
  logic rd_start;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic [7:0] cnt_byte;
  logic [1:0] gpio_view;
  logic [1:0] mon_link;
  logic mon_on;
  logic tmr_expire;
  qfg_link_counts_t cnt_sel;

  assign idx = I_AVS_ADDRESS[7:2];
  assign req = I_AVS_READ | I_AVS_WRITE;
  // one wait state: answer lands on the second edge
  assign O_AVS_WAITREQUEST = req & ~s_reg.ack;
  assign wr_en = I_AVS_WRITE & s_reg.ack & I_AVS_BYTEENABLE[0];
  assign rd_start = I_AVS_READ & ~s_reg.ack;
  assign wbyte = I_AVS_WRITEDATA[7:0];
  // reserved upper bits of every word read zero
  assign O_AVS_READDATA = {24'h000000, s_reg.rdata};

  // ==========================================
  // indirect counter byte
  // link pick for counters
  assign cnt_sel = I_LINK_COUNTS[s_reg.counter_link_select];

  always_comb begin
    unique case (s_reg.counter_addr)
      4'h0: cnt_byte = cnt_sel.crc_error_count[7:0];
      4'h1: cnt_byte = cnt_sel.crc_error_count[15:8];
      4'h2: cnt_byte = cnt_sel.framing_error_count[7:0];
      4'h3: cnt_byte = cnt_sel.framing_error_count[15:8];
      4'h4: cnt_byte = cnt_sel.frame_alignment_change_count;
      4'h5: cnt_byte = cnt_sel.out_of_frame_count;
      4'h6: cnt_byte = cnt_sel.pattern_detector_error_count[7:0];
      4'h7: cnt_byte = cnt_sel.pattern_detector_error_count[15:8];
      4'h8: cnt_byte = cnt_sel.line_code_violation_count[7:0];
      4'h9: cnt_byte = cnt_sel.line_code_violation_count[15:8];
      4'ha: cnt_byte = cnt_sel.dds_error_count[7:0];
      4'hb: cnt_byte = cnt_sel.dds_error_count[15:8];
      // addresses past the last counter read zero
      default: cnt_byte = 8'h00;
    endcase
  end

  // ==========================================
  // gpio read view
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_gpio
      assign gpio_view[g] = s_reg.gpio_dir[g] ? I_GPIO[g] :
                            s_reg.gpio_level[g];
      assign O_GPIO_OE[g] = ~s_reg.gpio_dir[g];
    end
  endgenerate
  assign O_GPIO = s_reg.gpio_level;

  // ==========================================
  // read mux
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      `QFG_IDX_MONITOR: rd_byte[3:0] = s_reg.monitor_path_select;
      `QFG_IDX_GPIO: begin
        rd_byte[`QFG_GPIO_DIR_LSB +: 2] = s_reg.gpio_dir;
        rd_byte[`QFG_GPIO_LEVEL_LSB +: 2] = gpio_view;
      end
      `QFG_IDX_REFCLK: begin
        rd_byte[`QFG_REF1_LSB +: 2] = s_reg.first_refclk_link_select;
        rd_byte[`QFG_REF2_LSB +: 2] = s_reg.second_refclk_link_select;
      end
      `QFG_IDX_SUMMARY: rd_byte[3:0] = I_LINK_INT;
      `QFG_IDX_TMR_EN: rd_byte[0] = s_reg.timer_interrupt_enable;
      `QFG_IDX_TMR_FLAG: rd_byte[0] = s_reg.timer_expired_flag;
      `QFG_IDX_LOSS_CFG: rd_byte[0] = s_reg.refclk_high_on_signal_loss;
      `QFG_IDX_CNT_SEL: begin
        rd_byte[`QFG_CNT_ADDR_LSB +: 4] = s_reg.counter_addr;
        rd_byte[`QFG_CNT_LINK_LSB +: 2] = s_reg.counter_link_select;
      end
      `QFG_IDX_CNT_DATA: rd_byte = cnt_byte;
      // unmapped index answers with zero
      default: rd_byte = 8'h00;
    endcase
  end

  // ==========================================
  // monitor decode
  // codes 0, 8 and reserved stay off
  assign mon_link = s_reg.monitor_path_select[1:0];
  assign mon_on = (mon_link != 2'h0) & ~s_reg.monitor_path_select[2];

  assign tmr_expire =
    (s_reg.timer_cnt == 32'(P_TIMER_CYCLES - 1));

  // ==========================================
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.ack = req & ~s_reg.ack;
    if (rd_start) begin
      s_next.rdata = rd_byte;
    end
    if (wr_en) begin
      unique case (idx)
        `QFG_IDX_MONITOR: begin
          s_next.monitor_path_select = wbyte[3:0];
        end
        `QFG_IDX_GPIO: begin
          s_next.gpio_dir = wbyte[`QFG_GPIO_DIR_LSB +: 2];
          for (int i = 0; i < 2; i++) begin
            if (!s_reg.gpio_dir[i]) begin
              s_next.gpio_level[i] = wbyte[`QFG_GPIO_LEVEL_LSB + i];
            end
          end
        end
        `QFG_IDX_REFCLK: begin
          s_next.first_refclk_link_select = wbyte[`QFG_REF1_LSB +: 2];
          s_next.second_refclk_link_select = wbyte[`QFG_REF2_LSB +: 2];
        end
        `QFG_IDX_TMR_EN: s_next.timer_interrupt_enable = wbyte[0];
        `QFG_IDX_LOSS_CFG: begin
          s_next.refclk_high_on_signal_loss = wbyte[0];
        end
        `QFG_IDX_TMR_FLAG: begin
          if (wbyte[0]) begin
            s_next.timer_expired_flag = 1'b0;
          end
        end
        `QFG_IDX_CNT_SEL: begin
          s_next.counter_addr = wbyte[`QFG_CNT_ADDR_LSB +: 4];
          s_next.counter_link_select = wbyte[`QFG_CNT_LINK_LSB +: 2];
        end
        // read-only and unmapped: write dropped
        default: s_next.rdata = s_reg.rdata;
      endcase
    end
    s_next.timer_cnt = tmr_expire ? 32'h00000000 :
                       s_reg.timer_cnt + 32'h00000001;
    // set beats a same-cycle clear
    if (tmr_expire) begin
      s_next.timer_expired_flag = 1'b1;
    end
    // monitored path; link 0 receive while off
    s_next.monitor_active = mon_on;
    if (!mon_on) begin
      s_next.monitor_data = I_LINK_RX_DATA[0];
    end else if (s_reg.monitor_path_select[3]) begin
      s_next.monitor_data = I_LINK_TX_DATA[mon_link];
    end else begin
      s_next.monitor_data = I_LINK_RX_DATA[mon_link];
    end
    if (I_LOSS_OF_SIGNAL[s_reg.first_refclk_link_select]) begin
      s_next.first_refclk_output = s_reg.refclk_high_on_signal_loss |
                                   I_MASTER_CLK;
    end else begin
      s_next.first_refclk_output =
        I_RECOVERED_CLK[s_reg.first_refclk_link_select];
    end
    if (I_LOSS_OF_SIGNAL[s_reg.second_refclk_link_select]) begin
      s_next.second_refclk_output = s_reg.refclk_high_on_signal_loss |
                                    I_MASTER_CLK;
    end else begin
      s_next.second_refclk_output =
        I_RECOVERED_CLK[s_reg.second_refclk_link_select];
    end
    s_next.int_n = ~((s_reg.timer_interrupt_enable &
                      s_reg.timer_expired_flag) | (|I_LINK_INT));
  end

  // ==========================================
  // state register
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s_reg <= '0;
      s_reg.monitor_path_select <= `QFG_RST_MONITOR;
      s_reg.gpio_dir <= `QFG_RST_GPIO_DIR;
      s_reg.gpio_level <= `QFG_RST_GPIO_LEVEL;
      s_reg.first_refclk_link_select <= `QFG_RST_REF_SEL;
      s_reg.second_refclk_link_select <= `QFG_RST_REF_SEL;
      s_reg.counter_addr <= `QFG_RST_CNT_ADDR;
      s_reg.counter_link_select <= `QFG_RST_CNT_LINK;
      s_reg.int_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================
  // outputs
  // clock outputs are sampled, so they carry only clocks well
  // below half of the system clock
  assign O_MONITOR_DATA = s_reg.monitor_data;
  assign O_MONITOR_ACTIVE = s_reg.monitor_active;
  assign O_FIRST_REFCLK_OUTPUT = s_reg.first_refclk_output;
  assign O_SECOND_REFCLK_OUTPUT = s_reg.second_refclk_output;
  assign O_INT_N = s_reg.int_n;

endmodule

`default_nettype wire

// [include/qfg_regs.svh]
`ifndef QFG_REGS_SVH
`define QFG_REGS_SVH

// ==========================================
// register indices (byte address = 4 * index)
`define QFG_IDX_MONITOR 6'h05
`define QFG_IDX_GPIO 6'h06
`define QFG_IDX_REFCLK 6'h07
`define QFG_IDX_SUMMARY 6'h09
`define QFG_IDX_TMR_EN 6'h0a
`define QFG_IDX_TMR_FLAG 6'h0b
`define QFG_IDX_LOSS_CFG 6'h0c
`define QFG_IDX_CNT_SEL 6'h0e
`define QFG_IDX_CNT_DATA 6'h0f

// ==========================================
// field positions
`define QFG_GPIO_DIR_LSB 0
`define QFG_GPIO_LEVEL_LSB 2
`define QFG_REF1_LSB 0
`define QFG_REF2_LSB 3
`define QFG_CNT_ADDR_LSB 0
`define QFG_CNT_LINK_LSB 5

// ==========================================
// reset values
`define QFG_RST_MONITOR 4'h0
`define QFG_RST_GPIO_DIR 2'h3
`define QFG_RST_GPIO_LEVEL 2'h0
`define QFG_RST_REF_SEL 2'h0
`define QFG_RST_CNT_ADDR 4'h0
`define QFG_RST_CNT_LINK 2'h0

// ==========================================
// timing
`define QFG_CLK_PERIOD_NS 20
`define QFG_TIMER_PERIOD_S 1
`define QFG_TIMER_CYCLES \
  ((`QFG_TIMER_PERIOD_S * 1000000000) / `QFG_CLK_PERIOD_NS)
`define QFG_CNT_ADDR_LAST 4'hb

`endif

// [include/qfg_pkg.sv]
package qfg_pkg;

  // ==========================================
  // per-link performance counters
  typedef struct packed {
    logic [15:0] crc_error_count;
    logic [15:0] framing_error_count;
    logic [7:0] frame_alignment_change_count;
    logic [7:0] out_of_frame_count;
    logic [15:0] pattern_detector_error_count;
    logic [15:0] line_code_violation_count;
    logic [15:0] dds_error_count;
  } qfg_link_counts_t;

  // ==========================================
  // whole block state
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [3:0] monitor_path_select;
    logic [1:0] gpio_dir;
    logic [1:0] gpio_level;
    logic [1:0] first_refclk_link_select;
    logic [1:0] second_refclk_link_select;
    logic refclk_high_on_signal_loss;
    logic timer_interrupt_enable;
    logic timer_expired_flag;
    logic [1:0] counter_link_select;
    logic [3:0] counter_addr;
    logic [31:0] timer_cnt;
    logic monitor_data;
    logic monitor_active;
    logic first_refclk_output;
    logic second_refclk_output;
    logic int_n;
  } qfg_state_t;

endpackage

// [sim/qfg_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// host side of the register bus
module qfg_host_model (
  // clock and answer
  input wire logic clk,
  input wire logic wt,
  input wire logic [31:0] rdat,
  // request
  output logic [7:0] adr,
  output logic rd,
  output logic wr,
  output logic [31:0] wd,
  output logic [3:0] be
);
  initial begin
    adr = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0;
    be = 4'h0;
  end
  // released lines show inverted data so stale values never match
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] din, output logic [7:0] dout);
    adr <= a;
    wd <= {24'h0, din};
    be <= 4'h1;
    rd <= ~w;
    wr <= w;
    do @(posedge clk); while (wt);
    dout = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    adr <= ~a;
    wd <= ~{24'h0, din};
    @(posedge clk);
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] x;
    xfer(1'b1, a, v, x);
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
    xfer(1'b0, a, 8'h00, v);
  endtask
endmodule
`default_nettype wire

// [sim/qfg_top_props.sv]
`timescale 1ns/10ps
`default_nettype none
module qfg_top_props (
  // watched ports
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic [7:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic [3:0] I_LINK_INT,
  input wire logic [1:0] I_GPIO,
  input wire logic [1:0] O_GPIO_OE,
  input wire logic [1:0] O_GPIO,
  input wire logic O_INT_N
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);
  sequence s_gw;
    I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_BYTEENABLE[0] &&
      I_AVS_ADDRESS[7:2] == 6'h06;
  endsequence
  sequence s_gr;
    I_AVS_READ && !O_AVS_WAITREQUEST && I_AVS_ADDRESS[7:2] == 6'h06;
  endsequence
  chk_wait_one: assert property ((I_AVS_READ || I_AVS_WRITE) &&
    O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST) else $error("no answer");
  chk_rd_pad: assert property (
    I_AVS_READ && !O_AVS_WAITREQUEST |-> O_AVS_READDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_sum_read: assert property (
    I_AVS_READ && !O_AVS_WAITREQUEST && I_AVS_ADDRESS[7:2] == 6'h09 |->
    O_AVS_READDATA[7:0] == {4'h0, $past(I_LINK_INT)})
    else $error("summary read wrong");
  chk_oe_out: assert property (
    s_gw ##0 I_AVS_WRITEDATA[1:0] == 2'h0 |-> ##[1:2] O_GPIO_OE == 2'h3)
    else $error("pins not driven");
  chk_oe_in: assert property (
    s_gw ##0 I_AVS_WRITEDATA[1:0] == 2'h3 |-> ##[1:2] O_GPIO_OE == 2'h0)
    else $error("pins still driven");
  chk_lvl_out: assert property (
    s_gw ##0 O_GPIO_OE == 2'h3 |=> O_GPIO == $past(I_AVS_WRITEDATA[3:2]))
    else $error("pin level not written");
  chk_gpio_in: assert property (
    s_gr ##0 O_GPIO_OE == 2'h0 |->
    O_AVS_READDATA[3:0] == {$past(I_GPIO), 2'h3})
    else $error("input level not read");
  chk_int_link: assert property (
    I_LINK_INT != 4'h0 |=> !O_INT_N) else $error("link int not shown");
endmodule
bind qfg_top qfg_top_props chk (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN),
  .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
  .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_LINK_INT(I_LINK_INT),
  .I_GPIO(I_GPIO), .O_GPIO_OE(O_GPIO_OE), .O_GPIO(O_GPIO),
  .O_INT_N(O_INT_N));
`default_nettype wire

// [sim/qfg_top_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module qfg_top_bench;
  import qfg_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, mclk = 1'b0;
  logic rd, wr, wt, mdat, mact, ref1, ref2, link_interrupt_summary;
  logic [7:0] adr, b, d;
  logic [7:0] lf = 8'h5e;
  logic [31:0] wd, rdat;
  logic [3:0] be;
  logic [3:0] lint = 4'h0, loss_of_signal = 4'h0, rclk = 4'h0, rx = 4'h0, tx = 4'h0;
  logic [1:0] gpi = 2'h2, gpo, oe;
  qfg_link_counts_t [3:0] cnts = '0;
  logic [3:0] mc[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
  logic [7:0] ra[6] = '{8'h14, 8'h18, 8'h1c, 8'h24, 8'h28, 8'h38};
  int fail_count = 0, n_tests = 0, cyc = 0;
  // pin level resolved from both drivers
  wire logic [1:0] pin = (oe & gpo) | (~oe & gpi);
  always #10 clk = ~clk;
  // short interval keeps the run brief, long enough to test the clear
  qfg_top #(.P_TIMER_CYCLES(200)) uut (
    .I_CLOCK(clk), .I_RSTN(rstn), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wt), .I_LINK_INT(lint),
    .I_LOSS_OF_SIGNAL(loss_of_signal), .I_RECOVERED_CLK(rclk), .I_MASTER_CLK(mclk),
    .I_LINK_COUNTS(cnts), .I_LINK_RX_DATA(rx), .I_LINK_TX_DATA(tx),
    .O_MONITOR_DATA(mdat), .O_MONITOR_ACTIVE(mact), .I_GPIO(pin),
    .O_GPIO(gpo), .O_GPIO_OE(oe), .O_FIRST_REFCLK_OUTPUT(ref1),
    .O_SECOND_REFCLK_OUTPUT(ref2), .O_INT_N(link_interrupt_summary));
  qfg_host_model host (.clk(clk), .wt(wt), .rdat(rdat), .adr(adr),
    .rd(rd), .wr(wr), .wd(wd), .be(be));
  task automatic rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    b = lf;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // counter bytes in indirect address order
  function automatic logic [7:0] cb(input qfg_link_counts_t c,
      input logic [3:0] a);
    logic [95:0] v;
    v = {c.dds_error_count, c.line_code_violation_count,
      c.pattern_detector_error_count, c.out_of_frame_count,
      c.frame_alignment_change_count, c.framing_error_count,
      c.crc_error_count};
    return (a > 4'hb) ? 8'h00 : v[a * 8 +: 8];
  endfunction
  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // a hang ends the run as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    for (int i = 0; i < 48; i++) begin
      rnd();
      cnts[i / 12][(i % 12) * 8 +: 8] <= b;
    end
    tick(5);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (ra[i]) begin
      host.bus_rd(ra[i], d);
      check(d, (i == 1) ? 8'h0b : 8'h00);
    end
    // monitor codes, never a reserved one
    foreach (mc[i]) begin
      rnd();
      rx <= b[3:0];
      tx <= b[7:4];
      host.bus_wr(8'h14, {4'h0, mc[i]});
      tick(2);
      check(mact, mc[i][1:0] != 2'h0);
      if (mc[i][1:0] != 2'h0) check(mdat, b[{mc[i][3], mc[i][1:0]}]);
    end
    for (int s = 0; s < 16; s++) begin
      rnd();
      rclk <= b[3:0];
      host.bus_wr(8'h1c, {3'h0, s[3:2], 1'b0, s[1:0]});
      tick(2);
      check({ref1, ref2}, {b[s[1:0]], b[s[3:2]]});
    end
    rclk <= 4'h0;
    loss_of_signal <= 4'h8;
    host.bus_wr(8'h30, 8'h01);
    tick(2);
    check({ref1, ref2}, 2'h3);
    rclk <= 4'h8;
    host.bus_wr(8'h30, 8'h00);
    tick(2);
    check({ref1, ref2}, 2'h0);
    mclk <= 1'b1;
    tick(2);
    check({ref1, ref2}, 2'h3);
    host.bus_wr(8'h18, 8'h00);
    rnd();
    host.bus_wr(8'h18, {4'hf, b[1:0], 2'h0});
    host.bus_rd(8'h18, d);
    check({d, oe, gpo}, {4'h0, b[1:0], 2'h0, 2'h3, b[1:0]});
    gpi <= b[3:2];
    host.bus_wr(8'h18, 8'h03);
    host.bus_wr(8'h18, 8'h0f);
    host.bus_rd(8'h18, d);
    check({d, oe}, {4'h0, b[3:2], 2'h3, 2'h0});
    lint <= b[3:0] | 4'h1;
    host.bus_rd(8'h24, d);
    check({d, link_interrupt_summary}, {4'h0, b[3:0] | 4'h1, 1'b0});
    lint <= 4'h0;
    for (int e = 0; e < 2; e++) begin
      host.bus_wr(8'h28, e[7:0]);
      // clear first so the poll sees a fresh expiry
      host.bus_wr(8'h2c, 8'h01);
      d = 8'h00;
      for (int k = 0; k < 80 && d !== 8'h01; k++) host.bus_rd(8'h2c, d);
      check({d, link_interrupt_summary}, {8'h01, e[0] == 1'b0});
    end
    host.bus_wr(8'h2c, 8'h00);
    host.bus_rd(8'h2c, d);
    check(d, 8'h01);
    host.bus_wr(8'h2c, 8'h01);
    host.bus_rd(8'h2c, d);
    check(d, 8'h00);
    host.bus_wr(8'h28, 8'h00);
    tick(2);
    check(link_interrupt_summary, 1'b1);
    for (int i = 0; i < 64; i++) begin
      host.bus_wr(8'h38, {1'b0, i[5:4], 1'b0, i[3:0]});
      host.bus_rd(8'h3c, d);
      check(d, cb(cnts[i[5:4]], i[3:0]));
    end
    host.bus_wr(8'h38, 8'hff);
    host.bus_rd(8'h38, d);
    check(d, 8'h6f);
    host.bus_rd(8'h40, d);
    check(d, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
